/* pfa_regs.sv */
`timescale 1ns/1ps
//Contract
// - Kernel enable set lets non-secure EL1 access all tuning registers.
// - Kernel enable clear: non-secure EL1 tuning access traps to EL2, class 0x18.
// - Kernel enable clear: non-secure EL1 control write traps; control reads allowed.
// - Kernel enable bit changes only from secure EL1, EL2 or EL3.
// - Non-secure EL1 write of kernel enable while set leaves it unchanged.
// - Both enables set let EL0 access all tuning registers.
// - Either enable clear: EL0 tuning access traps to EL1, class 0x18.
// - Stream valid bit selects programmed settings, else built-in defaults.
// - Stream bit 59 disables first-level prefetch, overriding tag bit.
// - Stream bit 58 disables second-level prefetch, overriding tag bit.
// - Stream bit 55 makes first-level prefetches weak, default strong.
// - Stream bit 54 makes second-level prefetches weak, default strong.
// - First-level stride units times 256 bytes; zero means default distance.
// - Second-level stride units times one kilobyte; zero means default distance.
// - Invalid injection set: no hardware prefetch, prefetch instructions strong.
// - Injection bit 62 makes first-level hardware prefetches weak.
// - Injection bit 61 makes second-level hardware prefetches weak.
// - Injection kind bit: zero load-type, one store-type prefetch.
// - Injection software weak bit makes prefetch instructions weak when set.
// - Queue offset is signed, 4-byte granular, minus to plus 16 MB.
// - First-level distance signed 4-byte granular; zero disables first level.
// - Second-level distance signed 4-byte granular; zero disables second level.
// - Tag functions 0x8-0xf pick injection sets 0-7; lower values stream mode.
// - Miss-triggered set issues only on first-level miss; otherwise every access.
// - Unconditional mode prefetches at access address plus programmed distance.
module pfa_regs (
    input  wire logic                         i_clk,
    input  wire logic                         i_rst,
    input  wire logic                         i_sr_valid,
    input  wire logic                         i_sr_write,
    input  wire logic [1:0]                   i_sr_op0,
    input  wire logic [2:0]                   i_sr_op1,
    input  wire logic [3:0]                   i_sr_crn,
    input  wire logic [3:0]                   i_sr_crm,
    input  wire logic [2:0]                   i_sr_op2,
    input  wire logic [63:0]                  i_sr_wdata,
    input  wire logic [1:0]                   i_sr_el,
    input  wire logic                         i_sr_secure,
    output logic                              o_sr_done,
    output logic                              o_sr_hit,
    output logic                              o_sr_trap,
    output logic [1:0]                        o_sr_trap_el,
    output logic [5:0]                        o_sr_trap_ec,
    output logic [63:0]                       o_sr_rdata,
    input  wire logic                         i_lk_valid,
    input  wire logic [pfa_pkg::FUNC_W-1:0]   i_lk_func,
    input  wire logic [63:0]                  i_lk_addr,
    input  wire logic                         i_lk_l1_miss,
    output logic                              o_pf_valid,
    output logic                              o_pf_stream_mode,
    output logic [pfa_pkg::SET_W-1:0]         o_pf_set,
    output logic                              o_pf_l1_en,
    output logic                              o_pf_l2_en,
    output logic                              o_pf_l1_weak,
    output logic                              o_pf_l2_weak,
    output logic                              o_pf_sw_weak,
    output logic                              o_pf_store_type,
    output logic                              o_pf_miss_mode,
    output logic                              o_pf_issue,
    output logic [pfa_pkg::UNITS_W-1:0]       o_pf_l1_units,
    output logic [pfa_pkg::UNITS_W-1:0]       o_pf_l2_units,
    output logic [63:0]                       o_pf_queue_offset,
    output logic [63:0]                       o_pf_l1_addr,
    output logic [63:0]                       o_pf_l2_addr
);
    import pfa_pkg::*;

    typedef struct packed {
        logic                         kae;
        logic                         uae;
        logic [63:0]                  stream;
        logic [NUM_SETS-1:0][63:0]    inj_ctrl;
        logic [NUM_SETS-1:0][63:0]    inj_dist;
        logic                         done;
        logic                         hit;
        logic                         trap;
        logic [1:0]                   trap_el;
        logic [5:0]                   trap_ec;
        logic [63:0]                  rdata;
        logic                         pf_valid;
        logic                         pf_stream_mode;
        logic [SET_W-1:0]             pf_set;
        logic                         pf_l1_en;
        logic                         pf_l2_en;
        logic                         pf_l1_weak;
        logic                         pf_l2_weak;
        logic                         pf_sw_weak;
        logic                         pf_store_type;
        logic                         pf_miss_mode;
        logic                         pf_issue;
        logic [UNITS_W-1:0]           pf_l1_units;
        logic [UNITS_W-1:0]           pf_l2_units;
        logic [63:0]                  pf_queue_offset;
        logic [63:0]                  pf_l1_addr;
        logic [63:0]                  pf_l2_addr;
    } pfa_state_t;

    pfa_state_t         st_ff;
    pfa_state_t         nxt_st;

    logic                base_hit;
    logic                ctrl_hit;
    logic                sd_hit;
    logic [NUM_SETS-1:0] ic_hit;
    logic [NUM_SETS-1:0] id_hit;
    pfa_reg_class_t      reg_class;
    logic [SET_W-1:0]    reg_set;
    logic                acc_allow;
    logic                acc_trap;
    logic [1:0]          acc_trap_el;
    logic                acc_keep_kae;
    logic [SET_W-1:0]    lk_set;

    logic                lk_stream_mode;
    logic                lk_l1_en;
    logic                lk_l2_en;
    logic                lk_l1_weak;
    logic                lk_l2_weak;
    logic                lk_sw_weak;
    logic                lk_store_type;
    logic                lk_miss_mode;
    logic                lk_issue;
    logic [UNITS_W-1:0]  lk_l1_units;
    logic [UNITS_W-1:0]  lk_l2_units;
    logic [63:0]         lk_queue_offset;
    logic [63:0]         lk_l1_addr;
    logic [63:0]         lk_l2_addr;

    // Address decode of the bank
    assign base_hit = (i_sr_op0 == OP0_SYS) && (i_sr_crn == CRN_PF);
    assign ctrl_hit = base_hit && (i_sr_op1 == OP1_KERNEL) && (i_sr_crm == CRM_CTRL_SD)
                      && (i_sr_op2 == OP2_FIRST);
    assign sd_hit   = base_hit && (i_sr_op1 == OP1_USER) && (i_sr_crm == CRM_CTRL_SD)
                      && (i_sr_op2 == OP2_FIRST);

    genvar g;
    generate
        for (g = 0; g < NUM_SETS; g++) begin : g_set_decode
            assign ic_hit[g] = base_hit && (i_sr_op1 == OP1_USER)
                               && (i_sr_crm == CRM_INJ_CTRL) && (i_sr_op2 == SET_W'(g));
            assign id_hit[g] = base_hit && (i_sr_op1 == OP1_USER)
                               && (i_sr_crm == CRM_INJ_DIST) && (i_sr_op2 == SET_W'(g));
        end
    endgenerate

    always_comb begin
        reg_set = i_sr_op2;
        if (!i_sr_valid) begin
            reg_class = RC_NONE;
        end else if (ctrl_hit) begin
            reg_class = RC_CTRL;
        end else if (sd_hit) begin
            reg_class = RC_STREAM;
        end else if (|ic_hit) begin
            reg_class = RC_INJ_CTRL;
        end else if (|id_hit) begin
            reg_class = RC_INJ_DIST;
        end else begin
            reg_class = RC_NONE;
        end
    end

    pfa_access_check u_access (
        .i_secure   (i_sr_secure),
        .i_el       (i_sr_el),
        .i_class    (reg_class),
        .i_write    (i_sr_write),
        .i_kae      (st_ff.kae),
        .i_uae      (st_ff.uae),
        .o_allow    (acc_allow),
        .o_trap     (acc_trap),
        .o_trap_el  (acc_trap_el),
        .o_keep_kae (acc_keep_kae)
    );

    // Tag function picks the injection set from its low bits
    assign lk_set = i_lk_func[SET_W-1:0];

    pfa_lookup u_lookup (
        .i_func         (i_lk_func),
        .i_stream       (st_ff.stream),
        .i_inj_ctrl     (st_ff.inj_ctrl[lk_set]),
        .i_inj_dist     (st_ff.inj_dist[lk_set]),
        .i_addr         (i_lk_addr),
        .i_l1_miss      (i_lk_l1_miss),
        .o_stream_mode  (lk_stream_mode),
        .o_l1_en        (lk_l1_en),
        .o_l2_en        (lk_l2_en),
        .o_l1_weak      (lk_l1_weak),
        .o_l2_weak      (lk_l2_weak),
        .o_sw_weak      (lk_sw_weak),
        .o_store_type   (lk_store_type),
        .o_miss_mode    (lk_miss_mode),
        .o_issue        (lk_issue),
        .o_l1_units     (lk_l1_units),
        .o_l2_units     (lk_l2_units),
        .o_queue_offset (lk_queue_offset),
        .o_l1_addr      (lk_l1_addr),
        .o_l2_addr      (lk_l2_addr)
    );

    always_comb begin
        nxt_st = st_ff;

        // Register access answer, one cycle after the request
        nxt_st.done    = i_sr_valid;
        nxt_st.hit     = i_sr_valid && (reg_class != RC_NONE);
        nxt_st.trap    = acc_trap;
        nxt_st.trap_el = acc_trap ? acc_trap_el : EL0;
        nxt_st.trap_ec = acc_trap ? EC_TUNING_TRAP : 6'h00;
        nxt_st.rdata   = REG_RESET;
        if (acc_allow && !i_sr_write) begin
            case (reg_class)
                RC_CTRL: begin
                    nxt_st.rdata[KAE_BIT] = st_ff.kae;
                    nxt_st.rdata[UAE_BIT] = st_ff.uae;
                end
                RC_STREAM: begin
                    nxt_st.rdata = st_ff.stream;
                end
                RC_INJ_CTRL: begin
                    nxt_st.rdata = st_ff.inj_ctrl[reg_set];
                end
                RC_INJ_DIST: begin
                    nxt_st.rdata = st_ff.inj_dist[reg_set];
                end
                default: begin
                    nxt_st.rdata = REG_RESET;
                end
            endcase
        end

        // Register writes, reserved bits dropped
        if (acc_allow && i_sr_write) begin
            case (reg_class)
                RC_CTRL: begin
                    nxt_st.uae = i_sr_wdata[UAE_BIT];
                    if (!acc_keep_kae) begin
                        nxt_st.kae = i_sr_wdata[KAE_BIT];
                    end
                end
                RC_STREAM: begin
                    nxt_st.stream = i_sr_wdata & SD_MASK;
                end
                RC_INJ_CTRL: begin
                    nxt_st.inj_ctrl[reg_set] = i_sr_wdata & INJ_CTRL_MASK;
                end
                RC_INJ_DIST: begin
                    nxt_st.inj_dist[reg_set] = i_sr_wdata & INJ_DIST_MASK;
                end
                default: begin
                    nxt_st.stream = st_ff.stream;
                end
            endcase
        end

        // Prefetch attributes for the engines, one cycle after the lookup
        nxt_st.pf_valid = i_lk_valid;
        if (i_lk_valid) begin
            nxt_st.pf_stream_mode  = lk_stream_mode;
            nxt_st.pf_set          = lk_set;
            nxt_st.pf_l1_en        = lk_l1_en;
            nxt_st.pf_l2_en        = lk_l2_en;
            nxt_st.pf_l1_weak      = lk_l1_weak;
            nxt_st.pf_l2_weak      = lk_l2_weak;
            nxt_st.pf_sw_weak      = lk_sw_weak;
            nxt_st.pf_store_type   = lk_store_type;
            nxt_st.pf_miss_mode    = lk_miss_mode;
            nxt_st.pf_issue        = lk_issue;
            nxt_st.pf_l1_units     = lk_l1_units;
            nxt_st.pf_l2_units     = lk_l2_units;
            nxt_st.pf_queue_offset = lk_queue_offset;
            nxt_st.pf_l1_addr      = lk_l1_addr;
            nxt_st.pf_l2_addr      = lk_l2_addr;
        end else begin
            nxt_st.pf_issue        = 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_sr_done         = st_ff.done;
    assign o_sr_hit          = st_ff.hit;
    assign o_sr_trap         = st_ff.trap;
    assign o_sr_trap_el      = st_ff.trap_el;
    assign o_sr_trap_ec      = st_ff.trap_ec;
    assign o_sr_rdata        = st_ff.rdata;
    assign o_pf_valid        = st_ff.pf_valid;
    assign o_pf_stream_mode  = st_ff.pf_stream_mode;
    assign o_pf_set          = st_ff.pf_set;
    assign o_pf_l1_en        = st_ff.pf_l1_en;
    assign o_pf_l2_en        = st_ff.pf_l2_en;
    assign o_pf_l1_weak      = st_ff.pf_l1_weak;
    assign o_pf_l2_weak      = st_ff.pf_l2_weak;
    assign o_pf_sw_weak      = st_ff.pf_sw_weak;
    assign o_pf_store_type   = st_ff.pf_store_type;
    assign o_pf_miss_mode    = st_ff.pf_miss_mode;
    assign o_pf_issue        = st_ff.pf_issue;
    assign o_pf_l1_units     = st_ff.pf_l1_units;
    assign o_pf_l2_units     = st_ff.pf_l2_units;
    assign o_pf_queue_offset = st_ff.pf_queue_offset;
    assign o_pf_l1_addr      = st_ff.pf_l1_addr;
    assign o_pf_l2_addr      = st_ff.pf_l2_addr;

endmodule

/* pfa_pkg.sv */
package pfa_pkg;

    // System register encoding of the bank
    localparam logic [1:0]  OP0_SYS        = 2'h3;
    localparam logic [2:0]  OP1_KERNEL     = 3'h0;
    localparam logic [2:0]  OP1_USER       = 3'h3;
    localparam logic [3:0]  CRN_PF         = 4'hb;
    localparam logic [3:0]  CRM_CTRL_SD    = 4'h4;
    localparam logic [3:0]  CRM_INJ_CTRL   = 4'h6;
    localparam logic [3:0]  CRM_INJ_DIST   = 4'h7;
    localparam logic [2:0]  OP2_FIRST      = 3'h0;

    // Exception levels and trap class
    localparam logic [1:0]  EL0            = 2'h0;
    localparam logic [1:0]  EL1            = 2'h1;
    localparam logic [1:0]  EL2            = 2'h2;
    localparam logic [5:0]  EC_TUNING_TRAP = 6'h18;

    // Field positions
    localparam int          KAE_BIT        = 63;
    localparam int          UAE_BIT        = 62;
    localparam int          SD_VALID_BIT   = 63;
    localparam int          SD_L1_OFF_BIT  = 59;
    localparam int          SD_L2_OFF_BIT  = 58;
    localparam int          SD_L1_WEAK_BIT = 55;
    localparam int          SD_L2_WEAK_BIT = 54;
    localparam int          SD_L1_UNITS_LSB = 24;
    localparam int          SD_L2_UNITS_LSB = 16;
    localparam int          UNITS_W        = 4;
    localparam int          INJ_VALID_BIT  = 63;
    localparam int          INJ_L1_WEAK_BIT = 62;
    localparam int          INJ_L2_WEAK_BIT = 61;
    localparam int          INJ_MISS_BIT   = 60;
    localparam int          INJ_STORE_BIT  = 59;
    localparam int          INJ_SWW_BIT    = 58;
    localparam int          INJ_OFF_LSB    = 2;
    localparam int          DIST_L1_LSB    = 34;
    localparam int          DIST_L2_LSB    = 2;
    localparam int          FIELD_W        = 23;
    localparam int          GRAN_BITS      = 2;
    localparam int          NUM_SETS       = 8;
    localparam int          SET_W          = 3;
    localparam int          FUNC_W         = 4;
    localparam int          FUNC_INJ_BIT   = 3;
    localparam int          FUNC_L1_OFF_BIT = 2;
    localparam int          FUNC_L2_OFF_BIT = 1;
    localparam int          FUNC_SWW_BIT   = 0;

    // Writable bits; every other bit reads zero
    localparam logic [63:0] CTRL_MASK      = 64'hc000_0000_0000_0000;
    localparam logic [63:0] SD_MASK        = 64'h8cc0_0000_0f0f_0000;
    localparam logic [63:0] INJ_CTRL_MASK  = 64'hfc00_0000_01ff_fffc;
    localparam logic [63:0] INJ_DIST_MASK  = 64'h01ff_fffc_01ff_fffc;
    localparam logic [63:0] REG_RESET      = 64'h0000_0000_0000_0000;

    typedef enum logic [2:0] {
        RC_NONE,
        RC_CTRL,
        RC_STREAM,
        RC_INJ_CTRL,
        RC_INJ_DIST
    } pfa_reg_class_t;

endpackage

/* pfa_access_check.sv */
`timescale 1ns/1ps
module pfa_access_check (
    input  wire logic                    i_secure,
    input  wire logic [1:0]              i_el,
    input  wire pfa_pkg::pfa_reg_class_t i_class,
    input  wire logic                    i_write,
    input  wire logic                    i_kae,
    input  wire logic                    i_uae,
    output logic                         o_allow,
    output logic                         o_trap,
    output logic [1:0]                   o_trap_el,
    output logic                         o_keep_kae
);
    import pfa_pkg::*;

    always_comb begin
        o_trap     = 1'b0;
        o_trap_el  = EL2;
        o_keep_kae = 1'b0;
        if (i_class != RC_NONE) begin
            if (i_el == EL0) begin
                if (i_class == RC_CTRL || !(i_kae && i_uae)) begin
                    o_trap    = 1'b1;
                    o_trap_el = EL1;
                end
            end else if (i_el == EL1 && !i_secure) begin
                if (i_class == RC_CTRL) begin
                    if (i_write && !i_kae) begin
                        o_trap = 1'b1;
                    end else if (i_write) begin
                        o_keep_kae = 1'b1;
                    end
                end else if (!i_kae) begin
                    o_trap = 1'b1;
                end
            end
        end
        o_allow = (i_class != RC_NONE) && !o_trap;
    end

endmodule

/* pfa_lookup.sv */
`timescale 1ns/1ps
module pfa_lookup (
    input  wire logic [pfa_pkg::FUNC_W-1:0]  i_func,
    input  wire logic [63:0]                 i_stream,
    input  wire logic [63:0]                 i_inj_ctrl,
    input  wire logic [63:0]                 i_inj_dist,
    input  wire logic [63:0]                 i_addr,
    input  wire logic                        i_l1_miss,
    output logic                             o_stream_mode,
    output logic                             o_l1_en,
    output logic                             o_l2_en,
    output logic                             o_l1_weak,
    output logic                             o_l2_weak,
    output logic                             o_sw_weak,
    output logic                             o_store_type,
    output logic                             o_miss_mode,
    output logic                             o_issue,
    output logic [pfa_pkg::UNITS_W-1:0]      o_l1_units,
    output logic [pfa_pkg::UNITS_W-1:0]      o_l2_units,
    output logic [63:0]                      o_queue_offset,
    output logic [63:0]                      o_l1_addr,
    output logic [63:0]                      o_l2_addr
);
    import pfa_pkg::*;

    localparam int SEXT_W = 64 - FIELD_W - GRAN_BITS;

    logic              sd_valid;
    logic              inj_valid;
    logic [FIELD_W-1:0] first_level_stride_units;
    logic [FIELD_W-1:0] second_level_stride_units;
    logic [FIELD_W-1:0] q_off;
    logic [63:0]       l1_bytes;
    logic [63:0]       l2_bytes;

    always_comb begin
        sd_valid  = i_stream[SD_VALID_BIT];
        inj_valid = i_inj_ctrl[INJ_VALID_BIT];
        first_level_stride_units   = i_inj_dist[DIST_L1_LSB +: FIELD_W];
        second_level_stride_units   = i_inj_dist[DIST_L2_LSB +: FIELD_W];
        q_off     = i_inj_ctrl[INJ_OFF_LSB +: FIELD_W];
        // Signed 4-byte-granular distances
        l1_bytes  = {{SEXT_W{first_level_stride_units[FIELD_W-1]}}, first_level_stride_units, {GRAN_BITS{1'b0}}};
        l2_bytes  = {{SEXT_W{second_level_stride_units[FIELD_W-1]}}, second_level_stride_units, {GRAN_BITS{1'b0}}};
        o_queue_offset = {{SEXT_W{q_off[FIELD_W-1]}}, q_off, {GRAN_BITS{1'b0}}};
        o_l1_addr = i_addr + l1_bytes;
        o_l2_addr = i_addr + l2_bytes;
        o_stream_mode = !i_func[FUNC_INJ_BIT];
        if (o_stream_mode) begin
            o_l1_en = !(i_func[FUNC_L1_OFF_BIT] || (sd_valid && i_stream[SD_L1_OFF_BIT]));
            o_l2_en = !(i_func[FUNC_L2_OFF_BIT] || (sd_valid && i_stream[SD_L2_OFF_BIT]));
            o_l1_weak    = sd_valid && i_stream[SD_L1_WEAK_BIT];
            o_l2_weak    = sd_valid && i_stream[SD_L2_WEAK_BIT];
            o_l1_units   = sd_valid ? i_stream[SD_L1_UNITS_LSB +: UNITS_W] : '0;
            o_l2_units   = sd_valid ? i_stream[SD_L2_UNITS_LSB +: UNITS_W] : '0;
            o_sw_weak    = i_func[FUNC_SWW_BIT];
            o_store_type = 1'b0;
            o_miss_mode  = 1'b0;
            o_issue      = 1'b0;
        end else begin
            o_l1_en      = inj_valid && (first_level_stride_units != '0);
            o_l2_en      = inj_valid && (second_level_stride_units != '0);
            o_l1_weak    = inj_valid && i_inj_ctrl[INJ_L1_WEAK_BIT];
            o_l2_weak    = inj_valid && i_inj_ctrl[INJ_L2_WEAK_BIT];
            o_sw_weak    = inj_valid && i_inj_ctrl[INJ_SWW_BIT];
            o_store_type = i_inj_ctrl[INJ_STORE_BIT];
            o_miss_mode  = i_inj_ctrl[INJ_MISS_BIT];
            o_l1_units   = '0;
            o_l2_units   = '0;
            o_issue      = inj_valid && (!o_miss_mode || i_l1_miss);
        end
    end

endmodule

/* pfa_pipe_model.sv */
`timescale 1ns/1ps
module pfa_pipe_model (
    input  wire logic        i_go,
    input  wire logic [63:0] i_addr,
    output logic             o_lk_valid,
    output logic [3:0]       o_lk_func,
    output logic [63:0]      o_lk_addr
);
    // Tag rides in the top nibble; an idle address shows inverted junk
    assign o_lk_valid = i_go;
    assign o_lk_func  = i_addr[63:60];
    assign o_lk_addr  = i_go ? i_addr : ~i_addr;
endmodule

/* pfa_regs_sva.sv */
`timescale 1ns/1ps
module pfa_regs_sva (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_sr_valid,
    input wire logic       i_sr_secure,
    input wire logic       o_sr_done,
    input wire logic       o_sr_trap,
    input wire logic       i_lk_valid,
    input wire logic       i_lk_l1_miss,
    input wire logic       o_pf_valid,
    input wire logic       o_pf_stream_mode,
    input wire logic       o_pf_l1_en,
    input wire logic       o_pf_issue,
    input wire logic       o_pf_miss_mode,
    input wire logic [1:0] i_sr_el,
    input wire logic [1:0] o_sr_trap_el,
    input wire logic [2:0] o_pf_set,
    input wire logic [3:0] i_lk_func,
    input wire logic [5:0] o_sr_trap_ec
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_trap_class: assert property (o_sr_trap |-> o_sr_trap_ec == 6'h18)
        else $error("bad class");
    a_user_trap: assert property (i_sr_valid && i_sr_el == 2'h0 |=>
        o_sr_done && (!o_sr_trap || o_sr_trap_el == 2'h1)) else $error("user trap");
    a_kernel_trap: assert property (i_sr_valid && i_sr_el == 2'h1 && !i_sr_secure |=>
        o_sr_done && (!o_sr_trap || o_sr_trap_el == 2'h2)) else $error("kernel trap");
    a_high_free: assert property (i_sr_valid && (i_sr_el[1] || i_sr_secure && i_sr_el[0]) |=>
        o_sr_done && !o_sr_trap) else $error("high trap");
    a_lookup_map: assert property (i_lk_valid |=> o_pf_valid &&
        {!o_pf_stream_mode, o_pf_set} == $past(i_lk_func)) else $error("lookup");
    a_stream_quiet: assert property (o_pf_stream_mode |-> !o_pf_issue)
        else $error("stream issue");
    a_tag_l1_off: assert property (i_lk_valid && i_lk_func[3:2] == 2'h1 |=> !o_pf_l1_en)
        else $error("tag off");
    a_miss_gate: assert property (o_pf_valid && o_pf_miss_mode && !o_pf_stream_mode
        && !$past(i_lk_l1_miss) |-> !o_pf_issue) else $error("miss gate");
endmodule
bind pfa_regs pfa_regs_sva u_sva (.*);

/* prefetch_assist_control_regs_tb.sv */
`timescale 1ns/1ps
module prefetch_assist_control_regs_tb;
    import pfa_pkg::*;
    logic i_clk = 0, i_rst = 1, i_sr_valid = 0, i_sr_write = 0, i_sr_secure = 0, go = 0;
    logic [1:0] i_sr_op0 = 2'h3, i_sr_el = 0, o_sr_trap_el;
    logic [2:0] i_sr_op1 = 0, i_sr_op2 = 0, o_pf_set;
    logic [3:0] i_sr_crn = 4'hb, i_sr_crm = 0, i_lk_func, o_pf_l1_units, o_pf_l2_units;
    logic [63:0] i_sr_wdata = 0, i_lk_addr, ad = 0, x, y, o_sr_rdata, o_pf_queue_offset;
    logic [63:0] o_pf_l1_addr, o_pf_l2_addr;
    logic i_lk_valid, i_lk_l1_miss = 0, o_sr_done, o_sr_hit, o_sr_trap, o_pf_valid;
    logic o_pf_stream_mode, o_pf_l1_en, o_pf_l2_en, o_pf_l1_weak, o_pf_l2_weak, o_pf_sw_weak;
    logic o_pf_store_type, o_pf_miss_mode, o_pf_issue;
    logic [5:0] o_sr_trap_ec;
    logic [31:0] r = 32'hde04;
    int n_errors = 0, tests_run = 0, cyc = 0;
    pfa_regs u_dut (.*);
    pfa_pipe_model u_pipe (.i_go(go), .i_addr(ad), .o_lk_valid(i_lk_valid),
        .o_lk_func(i_lk_func), .o_lk_addr(i_lk_addr));
    initial forever #4 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            finish_test();
        end
    end
    function automatic logic [63:0] rnd();
        logic [63:0] v;
        repeat (64) begin
            r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
            v = {v[62:0], r[31]};
        end
        return v;
    endfunction
    function automatic logic [63:0] sx(input logic [22:0] f);
        return {{39{f[22]}}, f, 2'b00};
    endfunction
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // ht: 2 hit, 3 hit and trap, 0 unmapped
    task automatic acc(int wr, o1, cm, o2, el, s, logic [63:0] d, int ht, logic [63:0] e);
        @(negedge i_clk);
        {i_sr_write, i_sr_op1, i_sr_crm, i_sr_op2, i_sr_el} = {wr[0], 3'(o1), 4'(cm), 3'(o2), 2'(el)};
        {i_sr_valid, i_sr_secure, i_sr_wdata} = {1'b1, s[0], d};
        @(negedge i_clk);
        i_sr_valid = 0;
        chk({o_sr_done, o_sr_hit, o_sr_trap, o_sr_trap_el, o_sr_trap_ec},
            {1'b1, 2'(ht), ht[0] ? {2'(el ? 2 : 1), 6'h18} : 8'h00});
        chk(o_sr_rdata, (wr != 0 || ht != 2) ? 64'h0 : e);
    endtask
    task automatic look(input logic [3:0] f);
        @(negedge i_clk);
        ad = rnd();
        ad[63:60] = f;
        i_lk_l1_miss = ad[0];
        go = 1;
        @(negedge i_clk);
        go = 0;
        chk(o_pf_valid, 1);
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst <= 0;
        acc(0, 0, 4, 0, 2, 0, 0, 2, 0);
        acc(0, 3, 4, 0, 1, 0, 0, 3, 0);
        acc(1, 0, 4, 0, 1, 0, '1, 3, 0);
        acc(0, 3, 7, 5, 0, 0, 0, 3, 0);
        acc(1, 0, 4, 0, 2, 0, '1, 2, 0);
        acc(0, 0, 4, 0, 1, 0, 0, 2, CTRL_MASK);
        acc(1, 0, 4, 0, 1, 0, 0, 2, 0);
        acc(0, 0, 4, 0, 1, 1, 0, 2, 64'h8000_0000_0000_0000);
        acc(0, 3, 6, 1, 0, 0, 0, 3, 0);
        acc(1, 3, 5, 0, 2, 0, '1, 0, 0);
        acc(1, 0, 4, 0, 1, 1, CTRL_MASK, 2, 0);
        for (int n = 0; n < 8; n++) begin
            x = rnd();
            x[63] = !n[0];
            y = rnd();
            if (n == 2) y[56:34] = 0;
            acc(1, 3, 6, n, 0, 0, x, 2, 0);
            acc(1, 3, 7, n, 1, 0, y, 2, 0);
            acc(0, 3, 6, n, 2, 0, 0, 2, x & INJ_CTRL_MASK);
            acc(0, 3, 7, n, 0, 0, 0, 2, y & INJ_DIST_MASK);
            look(4'h8 | 4'(n));
            chk({o_pf_l1_en, o_pf_l2_en}, {2{x[63]}} & {|y[56:34], |y[24:2]});
            chk({o_pf_l1_weak, o_pf_l2_weak, o_pf_sw_weak}, {3{x[63]}} & {x[62:61], x[58]});
            chk(o_pf_l1_addr, ad + sx(y[56:34]));
            chk(o_pf_l2_addr, ad + sx(y[24:2]));
            chk(o_pf_queue_offset, sx(x[24:2]));
            chk({o_pf_issue, o_pf_store_type, o_pf_miss_mode},
                {x[63] && (!x[60] || ad[0]), x[59], x[60]});
        end
        for (int k = 0; k < 8; k++) begin
            x = rnd();
            x[63] = k != 3;
            acc(1, 3, 4, 0, 0, 0, x, 2, 0);
            look(4'(k));
            chk({o_pf_l1_en, o_pf_l2_en}, {!(k[2] | x[63] & x[59]), !(k[1] | x[63] & x[58])});
            chk({o_pf_l1_weak, o_pf_l2_weak, o_pf_sw_weak}, {{2{x[63]}} & x[55:54], k[0]});
            chk({o_pf_l1_units, o_pf_l2_units}, {8{x[63]}} & {x[27:24], x[19:16]});
        end
        finish_test();
    end
endmodule
